/* ufe_fall_irq.sv */
// Purpose: Falling-edge enable aliases, live source status, fall events
// Assumes: Register port is the transceiver's own register access
// Notes:   Read data is registered; answer one cycle after reg_rd
`timescale 1ns/1ps
`default_nettype none
module ufe_fall_irq
#(
  // Id hold in cycles; shorten for simulation
  parameter int unsigned ID_HOLD_CYCLES = ufe_pkg::ID_HOLD_CYC
)
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Register access
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Analog interrupt sources
  input  wire logic        id_ground_raw,
  input  wire logic        session_end_raw,
  input  wire logic        a_device_session_valid,
  input  wire logic        vbus_valid_raw,
  input  wire logic        host_disconnect_raw,
  // Control levels from other registers
  input  wire logic        id_line_pull_up_enable,
  input  wire logic        plus_line_pull_down_enable,
  input  wire logic        minus_line_pull_down_enable,
  input  wire logic        low_power_mode,
  // Observed state
  output logic      [4:0]  fall_enable,
  output logic      [4:0]  irq_source_status,
  output logic      [4:0]  fall_event
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [4:0]                  en;     // Falling-edge enables
    logic [4:0]                  sts;    // Live status seen by software
    logic [4:0]                  evt;    // One-cycle fall events
    logic [7:0]                  rdata;  // Registered read data
    logic [ufe_pkg::HOLD_W-1:0]  hold;   // Id settle countdown
  } ufe_st_t;

  ufe_st_t st_q;
  ufe_st_t st_d;

  localparam logic [ufe_pkg::HOLD_W-1:0] HOLD_LOAD =
    ufe_pkg::HOLD_W'(ID_HOLD_CYCLES);

  // Raw and synchronised sources
  logic [4:0] src_async;
  logic [4:0] src_s;

  // ----------------------------------------------------------------------
  // Source synchroniser
  // ----------------------------------------------------------------------
  // Session valid is taken from the a-device valid signal
  assign src_async = {id_ground_raw, session_end_raw,
                      a_device_session_valid, vbus_valid_raw,
                      host_disconnect_raw};

  ufe_sync u_sync
  (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .src_async (src_async),
    .src_sync  (src_s)
  );

  // Derived controls
  logic host_mode;
  logic id_hold;
  logic [4:0] wmask;

  assign host_mode = plus_line_pull_down_enable &
                     minus_line_pull_down_enable;
  // Hold while pull-up off or still counting the settle time
  assign id_hold   = !id_line_pull_up_enable ||
                     (st_q.hold != '0);
  // Only bits 4:0 reach the enables
  assign wmask     = reg_wdata[4:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    // Enable updates; on the set and clear aliases, zero data bits leave bits alone
    if (reg_wr)
    begin
      unique case (reg_addr)
        ufe_pkg::ADDR_FALL_EN:
        begin
          st_d.en = wmask;
        end
        ufe_pkg::ADDR_FALL_EN_SET:
        begin
          st_d.en = st_q.en | wmask;
        end
        ufe_pkg::ADDR_FALL_EN_CLR:
        begin
          st_d.en = st_q.en & ~wmask;
        end
        default:
        begin
          // Status is read-only; other addresses ignored
          st_d.en = st_q.en;
        end
      endcase
    end
    // Settle countdown restarts whenever the pull-up is off
    if (!id_line_pull_up_enable)
    begin
      st_d.hold = HOLD_LOAD;
    end
    else if (st_q.hold != '0)
    begin
      st_d.hold = st_q.hold - 1'b1;
    end
    // Live levels, no latching
    st_d.sts = src_s;
    if (id_hold)
    begin
      st_d.sts[ufe_pkg::BIT_ID_GND] = st_q.sts[ufe_pkg::BIT_ID_GND];
    end
    // Low power drops host disconnect; level is the synchronised detector
    // output and resets to one, so it reads one while detached from reset on
    if (low_power_mode)
    begin
      st_d.sts[ufe_pkg::BIT_HOST_DISC] = 1'b0;
    end
    // Falling edges of the visible status, gated by enables
    st_d.evt = st_q.sts & ~st_d.sts & st_q.en;
    // Id is frozen while held, so no event slips through
    if (id_hold)
    begin
      st_d.evt[ufe_pkg::BIT_ID_GND] = 1'b0;
    end
    // Host disconnect event only counts in host mode; a drop caused
    // by low power is not a real disconnect edge
    if (!host_mode || low_power_mode)
    begin
      st_d.evt[ufe_pkg::BIT_HOST_DISC] = 1'b0;
    end
    // Read path
    if (reg_rd)
    begin
      unique case (reg_addr)
        ufe_pkg::ADDR_FALL_EN,
        ufe_pkg::ADDR_FALL_EN_SET,
        ufe_pkg::ADDR_FALL_EN_CLR:
        begin
          st_d.rdata = {ufe_pkg::RSVD_VAL, st_q.en};
        end
        ufe_pkg::ADDR_IRQ_STATUS:
        begin
          st_d.rdata = {ufe_pkg::RSVD_VAL, st_q.sts};
        end
        default:
        begin
          // Unmapped here: read as zero
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Whole state frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q.en    <= ufe_pkg::FALL_EN_RST;
      st_q.sts   <= ufe_pkg::SRC_RST;
      st_q.evt   <= 5'h00;
      st_q.rdata <= 8'h00;
      st_q.hold  <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  // Outputs from flops
  assign reg_rdata         = st_q.rdata;
  assign fall_enable       = st_q.en;
  assign irq_source_status = st_q.sts;
  assign fall_event        = st_q.evt;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_set_wr;
    ce && reg_wr && reg_addr == ufe_pkg::ADDR_FALL_EN_SET;
  endsequence

  sequence s_clr_wr;
    ce && reg_wr && reg_addr == ufe_pkg::ADDR_FALL_EN_CLR;
  endsequence

  sequence s_alias_rd;
    ce && reg_rd && (reg_addr == ufe_pkg::ADDR_FALL_EN_SET ||
                     reg_addr == ufe_pkg::ADDR_FALL_EN_CLR);
  endsequence

  a_set_alias_ones: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_set_wr |=> ((fall_enable & $past(wmask)) == $past(wmask)))
    else $error("set alias did not set bits");

  a_clr_alias_ones: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_clr_wr |=> ((fall_enable & $past(wmask)) == 5'h00))
    else $error("clear alias did not clear bits");

  a_zero_bits_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_set_wr or s_clr_wr) |=>
      ((fall_enable & ~$past(wmask)) == ($past(fall_enable) & ~$past(wmask))))
    else $error("zero data bit changed an enable");

  a_alias_read_back: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_alias_rd |=> (reg_rdata == {3'h0, $past(fall_enable)}))
    else $error("alias read differs from enable register");

  a_rsvd_read_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_id_status_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && id_hold) |=> $stable(irq_source_status[4]))
    else $error("id status moved during hold");

  a_lp_hdisc_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && low_power_mode) |=> (irq_source_status[0] == 1'b0 && !fall_event[0]))
    else $error("host disconnect not zero in low power");

  a_fall_event_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    fall_event[3] |-> ($past(irq_source_status[3]) &&
                       !irq_source_status[3] &&
                       $past(fall_enable[3])))
    else $error("session end event without enabled fall");

  a_hold_count_len: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && !id_line_pull_up_enable) |=> (st_q.hold == HOLD_LOAD && !fall_event[4]))
    else $error("id hold counter not reloaded");

endmodule
`default_nettype wire

/* ufe_fall_irq_enable_status_test.sv */
// Purpose: Self-checking bench for the fall enables and live status
// Assumes: ce high except one freeze check; id hold shortened to 20 cycles
// Notes:   Enable model is an int updated on every alias write taken with ce high
`timescale 1ns/1ps
`default_nettype none
module ufe_fall_irq_enable_status_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int HOLD = 20;      // Shortened id settle time
  logic       clk_sys = 1'b0;
  logic       nrst;
  logic       ce;                // Clock enable, low freezes the block
  logic [4:0] raw;               // {id,session_end_status,session_valid_status,vbus,hostdisc}
  logic       pull_up;
  logic       dp_pd;
  logic       dm_pd;
  logic       low_pw;
  logic       id_win = 1'b0;     // Window where id events are masked
  logic       id_ev = 1'b0;      // Any id event seen in that window
  logic [5:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic [4:0] fall_enable;
  logic [4:0] irq_source_status;
  logic [4:0] fall_event;
  int         n_errors = 0;
  int         checked = 0;
  int         en = 'h1f;         // Enable model
  int         seed = 32'h8775;
  int         d;
  int         k;

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  ufe_fall_irq #(.ID_HOLD_CYCLES(HOLD)) dut
  (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .id_ground_raw(raw[4]), .session_end_raw(raw[3]),
    .a_device_session_valid(raw[2]), .vbus_valid_raw(raw[1]),
    .host_disconnect_raw(raw[0]),
    .id_line_pull_up_enable(pull_up),
    .plus_line_pull_down_enable(dp_pd),
    .minus_line_pull_down_enable(dm_pd), .low_power_mode(low_pw),
    .fall_enable(fall_enable), .irq_source_status(irq_source_status),
    .fall_event(fall_event)
  );

  ufe_link lnk
  (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // Sticky catch of id events while the hold masks them
  always @(negedge clk_sys)
    if (id_win)
      id_ev <= id_ev | fall_event[4];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Raise a source, drop it, count event pulses; exactly exp, one if enabled and unmasked
  task automatic fall_chk(input int b, input int exp);
    logic [7:0] cnt;             // Four-state, so an unknown pulse shows
    cnt = 8'h00;
    raw[b] = 1'b1;
    repeat (6) @(negedge clk_sys);
    raw[b] = 1'b0;
    repeat (8)
    begin
      @(negedge clk_sys);
      cnt += fall_event[b];
    end
    chk(cnt, exp[7:0]);
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #80000;
    n_errors++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    raw = 5'h01;
    pull_up = 1'b1;
    dp_pd = 1'b1;
    dm_pd = 1'b1;
    low_pw = 1'b0;
    ce = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    chk({3'h0, fall_enable}, 8'h1f);
    lnk.rd(6'h13, rv);
    chk(rv, 8'h01);
    lnk.rd(6'h12, rv);
    chk(rv, 8'h1f);
    // Random set/clear, reserved bits included, read via other alias
    for (k = 0; k < 24; k++)
    begin
      d = $random(seed);
      if (d[8])
      begin
        lnk.wr(6'h11, d[7:0]);
        en = en | (d & 'h1f);
      end
      else
      begin
        lnk.wr(6'h12, d[7:0]);
        en = en & ~d & 'h1f;
      end
      lnk.rd(d[8] ? 6'h12 : 6'h11, rv);
      chk(rv, en[7:0]);
    end
    // Plain enable register replaces all five; reserved bits dropped
    lnk.wr(6'h10, 8'hea);
    en = 'h0a;
    lnk.rd(6'h11, rv);
    chk(rv, en[7:0]);
    // Live levels; a write to status must change nothing
    for (k = 0; k < 8; k++)
    begin
      d = $random(seed);
      raw = d[4:0];
      lnk.wr(6'h13, 8'hff);
      chk({3'h0, fall_enable}, en[7:0]);
      repeat (4) @(negedge clk_sys);
      lnk.rd(6'h13, rv);
      chk(rv, {3'h0, d[4:0]});
    end
    // Low power forces host disconnect low
    raw[0] = 1'b1;
    low_pw = 1'b1;
    repeat (4) @(negedge clk_sys);
    lnk.rd(6'h13, rv);
    chk({7'h0, rv[0]}, 8'h00);
    low_pw = 1'b0;
    // Id status frozen while pull-up off and for the hold after it
    raw[4] = 1'b1;
    repeat (4) @(negedge clk_sys);
    pull_up = 1'b0;
    id_win = 1'b1;
    raw[4] = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({7'h0, irq_source_status[4]}, 8'h01);
    pull_up = 1'b1;
    repeat (HOLD - 6) @(negedge clk_sys);
    chk({7'h0, irq_source_status[4]}, 8'h01);
    id_win = 1'b0;
    chk({7'h0, id_ev}, 8'h00);
    repeat (12) @(negedge clk_sys);
    chk({7'h0, irq_source_status[4]}, 8'h00);
    // Falling-edge events on every source, then masked cases
    lnk.wr(6'h11, 8'h1f);
    en = 'h1f;
    for (k = 0; k < 5; k++)
      fall_chk(k, 1);
    lnk.wr(6'h12, 8'h02);
    en = en & ~'h02 & 'h1f;
    fall_chk(1, 0);
    dp_pd = 1'b0;
    fall_chk(0, 0);
    // Frozen clock enable: a set write is not taken
    ce = 1'b0;
    lnk.wr(6'h11, 8'h1f);
    chk({3'h0, fall_enable}, en[7:0]);
    ce = 1'b1;
    lnk.rd(6'h12, rv);
    chk(rv, en[7:0]);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* ufe_link.sv */
// Purpose: Link-side model issuing single-byte register reads and writes
// Assumes: Called at a falling edge; answer one cycle after reg_rd
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module ufe_link
(
  // Clock
  input  wire logic       clk_sys,
  // Register access
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 6'h3f;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // One write; strobe stands over exactly one rising edge, then one
  // idle edge so a following call never reassigns in the same step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    reg_addr  = ~a;
    @(negedge clk_sys);
  endtask

  // One read; registered data is settled by the next falling edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd   = 1'b0;
    d        = reg_rdata;
    reg_addr = ~a;
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* ufe_pkg.sv */
// Purpose: Constants for the falling-edge enable aliases and live status
// Assumes: 250 MHz link-interface clock, 6-bit register addresses
// Notes:   Offsets, bit positions, nonzero reset values and the hold count live here
package ufe_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FALL_EN     = 6'h10; // Enable storage
  localparam logic [5:0] ADDR_FALL_EN_SET = 6'h11; // Set alias
  localparam logic [5:0] ADDR_FALL_EN_CLR = 6'h12; // Clear alias
  localparam logic [5:0] ADDR_IRQ_STATUS  = 6'h13; // Live status

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int NSRC          = 5;  // Sources in bits 4:0
  localparam int BIT_HOST_DISC = 0;
  localparam int BIT_VBUS_VAL  = 1;
  localparam int BIT_SESS_VAL  = 2;
  localparam int BIT_SESS_END  = 3;
  localparam int BIT_ID_GND    = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] FALL_EN_RST = 5'h1f; // All edges enabled
  localparam logic [4:0] SRC_RST     = 5'h01; // Host detached by default
  localparam logic [2:0] RSVD_VAL    = 3'h0;  // Bits 7:5

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int ID_HOLD_MS  = 50;   // Id settle time after pull-up on
  localparam int CLK_MHZ     = 250;  // clk_sys rate
  localparam int ID_HOLD_CYC = ID_HOLD_MS * CLK_MHZ * 1000;
  localparam int HOLD_W      = 24;   // Counter width for the hold

endpackage

/* ufe_sync.sv */
// Purpose: Two-stage synchroniser for the analog interrupt sources
// Assumes: Sources change slowly relative to clk_sys
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ufe_sync
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    ce,
  // Asynchronous levels in, synchronous levels out
  input  wire logic [ufe_pkg::NSRC-1:0] src_async,
  output logic      [ufe_pkg::NSRC-1:0] src_sync
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [ufe_pkg::NSRC-1:0] s1; // Metastability catcher
    logic [ufe_pkg::NSRC-1:0] s2; // Safe to use
  } ufe_sync_st_t;

  ufe_sync_st_t st_q;
  ufe_sync_st_t st_d;

  // Per-bit next state
  genvar gi;
  generate
    for (gi = 0; gi < ufe_pkg::NSRC; gi++)
    begin : g_bit
      always_comb
      begin
        st_d.s1[gi] = src_async[gi];
        st_d.s2[gi] = st_q.s1[gi];
      end
    end
  endgenerate

  // Registers, frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= {ufe_pkg::SRC_RST, ufe_pkg::SRC_RST};
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign src_sync = st_q.s2;

endmodule
`default_nettype wire
